// ---- hdl/pcc_top.sv ----
// Purpose: port pin configuration, routing matrix and event capture
// Assumes: configuration inputs are software register contents
// Notes:   every output is registered, so a configuration change shows one clock later
`timescale 1ns/1ns
`default_nettype none
module pcc_top (
  input  wire logic                    sys_clk,     // 100 MHz clock
  input  wire logic                    resetn,      // async, active low
  input  wire logic                    routing_matrix_enable, // matrix on
  input  wire logic                    pullup_global_disable, // pulls off
  input  wire logic [pcc_pkg::NPIN-1:0] pin_input_kind_select, // 1 dig
  input  wire logic [pcc_pkg::NPIN-1:0] pin_drive_style_select, // 1 pp
  input  wire logic [pcc_pkg::NROUTE-1:0] route_bypass_bits, // 1 skip
  input  wire logic [pcc_pkg::NPIN-1:0] gpio_out_value,  // port latch out
  input  wire logic [3:0]              peripheral_route_select_a, // ser
  input  wire logic [5:0]              peripheral_route_select_b, // cnt
  input  wire logic                    peripheral_route_select_c, // ser 2
  input  wire logic [pcc_pkg::NSIG-1:0] periph_sig_out,   // peripheral out
  input  wire logic [pcc_pkg::NSIG-1:0] periph_sig_drive, // wants drive
  input  wire logic [7:0]              ext_irq_pin_select, // pins, pol
  input  wire logic [7:0]              port0_compare_mask,  // match mask
  input  wire logic [7:0]              port0_compare_value, // match value
  input  wire logic [6:0]              port1_compare_mask,  // match mask
  input  wire logic [6:0]              port1_compare_value, // match value
  input  wire logic [2:0]              ext_osc_control,  // osc mode field
  input  wire logic                    debug_link_active,   // owns P2.0
  input  wire logic                    debug_link_data_out, // debug drive
  input  wire logic                    debug_link_data_oe,  // debug enable
  input  wire logic [pcc_pkg::NPIN-1:0] pad_in,           // pad levels
  output logic [pcc_pkg::NPIN-1:0]     pad_out,     // pad drive level
  output logic [pcc_pkg::NPIN-1:0]     pad_oe,      // pad driver on
  output logic [pcc_pkg::NPIN-1:0]     pad_pullup,  // weak pull-up on
  output logic [pcc_pkg::NPIN-1:0]     port_read,   // port pin read
  output logic [pcc_pkg::NSIG-1:0]     periph_sig_in,     // pad to periph
  output logic [pcc_pkg::NSIG-1:0]     periph_sig_placed, // got a pin
  output logic                         ext_irq0_level,    // irq 0 active
  output logic                         ext_irq1_level,    // irq 1 active
  output logic                         port_match,        // wake level
  output logic                         osc_pin_in_connect,  // P0.2 to osc
  output logic                         osc_pin_out_connect, // P0.3 to osc
  output logic                         debug_link_data_in   // P2.0 level
);
  import pcc_pkg::*;

  // lowest free unbypassed pin per enabled signal, serial port 0 fixed
  function automatic pcc_owner_t pcc_route(
    input logic [NSIG-1:0]   en,
    input logic [NROUTE-1:0] skip
  );
    logic [NROUTE-1:0] used;
    logic              found;
    pcc_route = {NROUTE{OWNER_NONE}};
    used      = skip;                                     // see R10 R13
    if (en[SIG_TX0]) begin
      pcc_route[PIN_TX0] = 5'(SIG_TX0);                   // see R12
      used[PIN_TX0]      = 1'b1;
    end
    if (en[SIG_RX0]) begin
      pcc_route[PIN_RX0] = 5'(SIG_RX0);                   // see R12
      used[PIN_RX0]      = 1'b1;
    end
    for (int s = SIG_SPI; s < NSIG; s++) begin
      found = 1'b0;
      for (int p = 0; p < NROUTE; p++) begin
        if (en[s] && !found && !used[p]) begin
          pcc_route[p] = 5'(s);
          used[p]      = 1'b1;
          found        = 1'b1;
        end
      end
    end
  endfunction : pcc_route

  logic [NSIG-1:0] sig_en;
  pcc_owner_t      owner_c;
  logic [NPIN-1:0] drv_req, out_val, pp;
  logic [NPIN-1:0] pad_lvl, c_oe, c_out, c_pu, c_rd;
  logic [NPIN-1:0] pad_out_d, pad_oe_d, pad_pullup_d, port_read_d;
  logic [NSIG-1:0] sig_in_d, placed_d;
  logic            irq0_d, irq1_d, match_d, xin_d, xout_d, dbg_in_d;
  logic [NPIN-1:0] pad_out_q, pad_oe_q, pad_pullup_q, port_read_q;
  logic [NSIG-1:0] sig_in_q, placed_q;
  logic            irq0_q, irq1_q, match_q, xin_q, xout_q, dbg_in_q;

  // routing: expand selects, place signals, pick what each pin drives
  always_comb begin
    sig_en = '0;
    sig_en[SIG_TX0] = peripheral_route_select_a[0];
    sig_en[SIG_RX0] = peripheral_route_select_a[0];
    sig_en[SIG_SPI +: 4] = {4{peripheral_route_select_a[1]}};
    sig_en[SIG_SMB +: 2] = {2{peripheral_route_select_a[2]}};
    sig_en[SIG_CLK] = peripheral_route_select_a[3];
    sig_en[SIG_CEX]     = peripheral_route_select_b[2:0] >= 3'h1;
    sig_en[SIG_CEX + 1] = peripheral_route_select_b[2:0] >= 3'h2;
    sig_en[SIG_CEX + 2] = peripheral_route_select_b[2:0] >= 3'h3;
    sig_en[SIG_ECI] = peripheral_route_select_b[3];
    sig_en[SIG_T0]  = peripheral_route_select_b[4];
    sig_en[SIG_T1]  = peripheral_route_select_b[5];
    sig_en[SIG_U1 +: 2] = {2{peripheral_route_select_c}};
    owner_c = pcc_route(sig_en, route_bypass_bits);       // see R10 R13
    drv_req = {NPIN{routing_matrix_enable}};              // see R2 R22
    out_val = gpio_out_value;
    pp      = pin_drive_style_select;                     // see R20
    for (int p = 0; p < NROUTE; p++) begin
      if (owner_c[p] != OWNER_NONE) begin
        out_val[p] = periph_sig_out[owner_c[p]];
        drv_req[p] = routing_matrix_enable & periph_sig_drive[owner_c[p]];
        // the two-wire serial bus pins are always open-drain
        if (owner_c[p] == 5'(SIG_SMB) || owner_c[p] == 5'(SIG_SMB + 1)) begin
          pp[p] = 1'b0;
        end
      end
    end
  end

  // one synchroniser and one cell per pin; pin 15 is never routed
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    pcc_sync3 u_sync (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .async_in   (pad_in[g]),
      .stable_out (pad_lvl[g])
    );
    pcc_pin_cell u_cell (
      .digital   (pin_input_kind_select[g]),              // see R21
      .push_pull (pp[g]),
      .drive_req (drv_req[g]),
      .out_val   (out_val[g]),
      .pu_dis    (pullup_global_disable),
      .pad_lvl   (pad_lvl[g]),
      .oe        (c_oe[g]),
      .out       (c_out[g]),
      .pu_on     (c_pu[g]),
      .rd        (c_rd[g])
    );
  end

  // next output values; reads ignore routing entirely
  always_comb begin
    pad_oe_d     = c_oe;
    pad_out_d    = c_out;
    pad_pullup_d = c_pu;
    port_read_d  = c_rd;                                  // see R1 R9
    sig_in_d     = '0;
    placed_d     = '0;
    for (int p = 0; p < NROUTE; p++) begin
      if (owner_c[p] != OWNER_NONE) begin
        sig_in_d[owner_c[p]] = c_rd[p];
        placed_d[owner_c[p]] = 1'b1;
      end
    end
    // debug link borrows the shared pad while active
    if (debug_link_active) begin
      pad_oe_d[PIN_DBG]     = debug_link_data_oe;         // see R14
      pad_out_d[PIN_DBG]    = debug_link_data_out;
      pad_pullup_d[PIN_DBG] = 1'b0;
    end
    dbg_in_d = pad_lvl[PIN_DBG];
    // analog pins are masked by input kind, so they never trigger capture
    irq0_d = pin_input_kind_select[ext_irq_pin_select[2:0]]   // see R16
           & (pad_lvl[ext_irq_pin_select[2:0]] == ext_irq_pin_select[3]);
    irq1_d = pin_input_kind_select[ext_irq_pin_select[6:4]]   // see R17
           & (pad_lvl[ext_irq_pin_select[6:4]] == ext_irq_pin_select[7]);
    match_d = |((c_rd[NROUTE-1:0]                             // see R15
              ^ {port1_compare_value, port0_compare_value})
              & {port1_compare_mask, port0_compare_mask}
              & pin_input_kind_select[NROUTE-1:0]);
    xin_d  = (ext_osc_control[2:1] == OSC_XTAL)               // see R11
           & route_bypass_bits[PIN_XIN];
    xout_d = ((ext_osc_control[2:1] == OSC_XTAL)
           | (ext_osc_control == OSC_RC) | (ext_osc_control == OSC_CAP))
           & route_bypass_bits[PIN_XOUT];
  end

  // output registers: reset leaves pads floating with pull-ups on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pad_oe_q     <= OE_RST;                             // see R2
      pad_out_q    <= '0;
      pad_pullup_q <= PULLUP_RST;
      port_read_q  <= '0;
      sig_in_q     <= '0;
      placed_q     <= '0;
      irq0_q       <= 1'b0;
      irq1_q       <= 1'b0;
      match_q      <= 1'b0;
      xin_q        <= 1'b0;
      xout_q       <= 1'b0;
      dbg_in_q     <= 1'b0;
    end else begin
      pad_oe_q     <= pad_oe_d;                           // see R23
      pad_out_q    <= pad_out_d;
      pad_pullup_q <= pad_pullup_d;
      port_read_q  <= port_read_d;
      sig_in_q     <= sig_in_d;
      placed_q     <= placed_d;
      irq0_q       <= irq0_d;
      irq1_q       <= irq1_d;
      match_q      <= match_d;
      xin_q        <= xin_d;
      xout_q       <= xout_d;
      dbg_in_q     <= dbg_in_d;
    end
  end

  assign pad_oe              = pad_oe_q;
  assign pad_out             = pad_out_q;
  assign pad_pullup          = pad_pullup_q;
  assign port_read           = port_read_q;
  assign periph_sig_in       = sig_in_q;
  assign periph_sig_placed   = placed_q;
  assign ext_irq0_level      = irq0_q;
  assign ext_irq1_level      = irq1_q;
  assign port_match          = match_q;
  assign osc_pin_in_connect  = xin_q;
  assign osc_pin_out_connect = xout_q;
  assign debug_link_data_in  = dbg_in_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_pad_steady;
    (pin_input_kind_select[0] && $stable(pad_in[0]))[*6];
  endsequence

  a_drivers_off_disabled: assert property ( // see R2 R22
    !routing_matrix_enable && !debug_link_active |=> pad_oe == 16'h0000)
    else $error("driver on while routing disabled");
  a_analog_pin_quiet: assert property ( // see R3 R4
    1'b1 |=> ((pad_oe[14:0] | pad_pullup[14:0] | port_read[14:0])
              & ~$past(pin_input_kind_select[14:0])) == 15'h0000)
    else $error("analog pin active");
  a_push_pull_drive: assert property ( // see R5
    routing_matrix_enable && !debug_link_active
    && pin_input_kind_select[15] && pin_drive_style_select[15]
    |=> pad_oe[15] && pad_out[15] == $past(gpio_out_value[15]))
    else $error("push-pull pad not following value");
  a_open_drain_float: assert property ( // see R6
    routing_matrix_enable && !debug_link_active
    && pin_input_kind_select[15] && !pin_drive_style_select[15]
    |=> pad_oe[15] == !$past(gpio_out_value[15]) && !pad_out[15])
    else $error("open-drain pad wrong");
  a_pullup_not_low: assert property ( // see R7
    (pad_pullup & pad_oe & ~pad_out) == 16'h0000)
    else $error("pull-up on while driving low");
  a_pullup_global_off: assert property ( // see R8
    pullup_global_disable |=> pad_pullup == 16'h0000)
    else $error("pull-up on while globally disabled");
  a_read_pad_level: assert property ( // see R9 R1
    s_pad_steady |=> port_read[0] == $past(pad_in[0]))
    else $error("read does not follow pad");
  a_bypass_never_claimed: assert property ( // see R10 R13
    (peripheral_route_select_a[0] == 1'b0) |->
    (route_bypass_bits & {owner_c[14] != OWNER_NONE,
      owner_c[13] != OWNER_NONE, owner_c[12] != OWNER_NONE,
      owner_c[11] != OWNER_NONE, owner_c[10] != OWNER_NONE,
      owner_c[9] != OWNER_NONE, owner_c[8] != OWNER_NONE,
      owner_c[7] != OWNER_NONE, owner_c[6] != OWNER_NONE,
      owner_c[5] != OWNER_NONE, owner_c[4] != OWNER_NONE,
      owner_c[3] != OWNER_NONE, owner_c[2] != OWNER_NONE,
      owner_c[1] != OWNER_NONE, owner_c[0] != OWNER_NONE}) == 15'h0000)
    else $error("bypassed pin claimed");
  a_serial_fixed_pins: assert property ( // see R12
    peripheral_route_select_a[0] |=> periph_sig_placed[1:0] == 2'h3
    && $past(owner_c[PIN_TX0]) == 5'(SIG_TX0))
    else $error("serial port not on fixed pins");
  a_osc_crystal_pins: assert property ( // see R11
    ext_osc_control[2:1] == OSC_XTAL && route_bypass_bits[PIN_XIN]
    && route_bypass_bits[PIN_XOUT]
    |=> osc_pin_in_connect && osc_pin_out_connect)
    else $error("crystal pins not connected");
  a_irq_analog_silent: assert property ( // see R16
    !pin_input_kind_select[ext_irq_pin_select[2:0]] |=> !ext_irq0_level)
    else $error("irq from analog pin");

  // debug ownership, idle pads and open-drain limits
  a_debug_owns_pad: assert property ( // see R14
    debug_link_active |=> pad_oe[15] == $past(debug_link_data_oe)
    && pad_out[15] == $past(debug_link_data_out) && !pad_pullup[15])
    else $error("debug link does not own shared pad");
  a_idle_pads_pulled: assert property ( // see R2 R7 R21
    !routing_matrix_enable && !pullup_global_disable && !debug_link_active
    |=> pad_pullup == $past(pin_input_kind_select))
    else $error("idle pad pull-up wrong");
  a_drain_never_high: assert property ( // see R6
    1'b1 |=> (pad_oe[14:0] & pad_out[14:0]
              & ~$past(pin_drive_style_select[14:0])) == 15'h0000)
    else $error("open-drain pad driven high");

  // a setting must reach the pad on the very next edge, not later
  sequence s_pin15_pp_high;
    routing_matrix_enable && !debug_link_active && pin_input_kind_select[15]
    && pin_drive_style_select[15] && gpio_out_value[15];
  endsequence
  a_config_next_cycle: assert property ( // see R23
    s_pin15_pp_high |=> pad_oe[15] && pad_out[15] && !pad_pullup[15])
    else $error("pin setting late on the pad");

  // oscillator pins stay free unless a mode claims them
  a_osc_off_free: assert property ( // see R11
    !ext_osc_control[2] |=> !osc_pin_in_connect && !osc_pin_out_connect)
    else $error("oscillator pin taken while off");
  a_rc_one_pin: assert property ( // see R11
    ext_osc_control == OSC_RC || ext_osc_control == OSC_CAP
    |=> !osc_pin_in_connect)
    else $error("rc mode took the input pin");
  a_irq1_analog_silent: assert property ( // see R16 R17
    !pin_input_kind_select[ext_irq_pin_select[6:4]] |=> !ext_irq1_level)
    else $error("irq from analog pin");
endmodule : pcc_top
`default_nettype wire

// ---- include/pcc_pkg.sv ----
// Purpose: constants and types for the port pin cell configuration block
// Assumes: sixteen pins, index 0-7 port 0, 8-14 port 1, 15 port 2 pin 0
// Notes:   routed pins are 0-14; pin 15 is general purpose only
// Behaviour
// R1 - port read always returns pin state, whatever the routing setup
// R2 - after reset pads are high impedance with pull-ups until routing enabled
// R3 - analog pins have pull-up, driver and receiver off
// R4 - analog pins always read as 0
// R5 - push-pull pins drive the pad high or low from output value
// R6 - open-drain pins only pull low; output 1 floats the pad
// R7 - undriven digital pad gets pull-up; pull-up off while driving low
// R8 - global pull-up disable turns every pull-up off
// R9 - digital pins read the pad level, not the output value
// R10 - bypassed pins are never claimed by the routing matrix; the code still puts serial port 0 on P0.4 and P0.5 when they are bypassed
// R11 - oscillator uses P0.2 and P0.3 for crystal, P0.3 for RC or C
// R12 - first async serial port always lands on P0.4 and P0.5
// R13 - routed peripherals go only to unbypassed pins P0.0 to P1.6; the code still puts serial port 0 on P0.4 and P0.5 when they are bypassed
// R14 - P2.0 is general purpose only, shared with debug link data
// R15 - pin transitions can raise interrupts or wake through event capture
// R16 - event capture works on digital pins, never on analog pins
// R17 - two external interrupts pick P0.0-P0.7; port match covers P0.0-P1.6
// R18 - software bypasses pins used as GPIO or unrouted functions
// R19 - software sets oscillator pins analog and bypassed
// R20 - software picks push-pull or open-drain for every digital pin; the code forces routed two-wire serial bus pins to open-drain
// R21 - input kind 1 means digital, 0 analog; reset leaves digital inputs
// R22 - all output drivers off while routing matrix is disabled; the code still lets an active debug link drive P2.0
// R23 - configuration changes reach the pad one clock after the write

`default_nettype none
package pcc_pkg;
  localparam int NPIN   = 16;   // all pins
  localparam int NROUTE = 15;   // pins the routing matrix may claim
  localparam int NSIG   = 17;   // routed peripheral signals
  localparam int PIN_TX0  = 4;
  localparam int PIN_RX0  = 5;
  localparam int PIN_XIN  = 2;
  localparam int PIN_XOUT = 3;
  localparam int PIN_DBG  = 15;
  // signal indices in priority order
  localparam int SIG_TX0  = 0;
  localparam int SIG_RX0  = 1;
  localparam int SIG_SPI  = 2;  // four signals
  localparam int SIG_SMB  = 6;  // two signals
  localparam int SIG_CLK  = 8;
  localparam int SIG_CEX  = 9;  // three channels
  localparam int SIG_ECI  = 12;
  localparam int SIG_T0   = 13;
  localparam int SIG_T1   = 14;
  localparam int SIG_U1   = 15; // two signals
  localparam logic [4:0]  OWNER_NONE = 5'h1F;
  localparam logic [15:0] PULLUP_RST = 16'hFFFF;
  localparam logic [15:0] OE_RST     = 16'h0000;
  localparam logic        SYNC_RST   = 1'b1;  // idle pads sit pulled high
  // oscillator mode field codes
  localparam logic [1:0]  OSC_XTAL   = 2'h3;  // upper two bits, crystal
  localparam logic [2:0]  OSC_RC     = 3'h4;
  localparam logic [2:0]  OSC_CAP    = 3'h5;
  typedef logic [NROUTE-1:0][4:0] pcc_owner_t;
endpackage : pcc_pkg
`default_nettype wire

// ---- hdl/pcc_sync3.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input comes from a pad outside the clock domain
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pcc_sync3 (
  input  wire logic sys_clk,   // system clock
  input  wire logic resetn,    // async reset, active low
  input  wire logic async_in,  // raw pad level
  output logic      stable_out // filtered level
);
  import pcc_pkg::*;
  logic s1_q, s2_q, s3_q, stable_q, stable_d;

  // first stage feeds only the second, never the filter
  always_comb begin
    stable_d = (s2_q == s3_q) ? s3_q : stable_q;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q     <= SYNC_RST;
      s2_q     <= SYNC_RST;
      s3_q     <= SYNC_RST;
      stable_q <= SYNC_RST;
    end else begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
    end
  end

  assign stable_out = stable_q;
endmodule : pcc_sync3
`default_nettype wire

// ---- hdl/pcc_pin_cell.sv ----
// Purpose: combinational model of one pin cell's driver and pull-up
// Assumes: caller registers the outputs toward the pad
// Notes:   drive_req already carries the routing enable gate
`timescale 1ns/1ns
`default_nettype none
module pcc_pin_cell (
  input  wire logic digital,    // 1 digital, 0 analog
  input  wire logic push_pull,  // 1 push-pull, 0 open-drain
  input  wire logic drive_req,  // driver allowed this cycle
  input  wire logic out_val,    // output logic value
  input  wire logic pu_dis,     // global pull-up disable
  input  wire logic pad_lvl,    // synchronised pad level
  output logic      oe,         // driver on
  output logic      out,        // driven level
  output logic      pu_on,      // weak pull-up on
  output logic      rd          // read-back value
);
  // open-drain only switches the low side on
  always_comb begin
    oe     = digital & drive_req & (push_pull | ~out_val); // see R5 R6 R3
    out    = push_pull & out_val;                         // see R6
    pu_on  = digital & ~pu_dis & ~oe;                     // see R7 R8 R3
    rd     = digital & pad_lvl;                           // see R4 R9
  end
endmodule : pcc_pin_cell
`default_nettype wire

// ---- sim/pcc_pad_model.sv ----
// Purpose: external circuits hanging on the sixteen pads
// Assumes: bench says which pads are driven from outside and to what
// Notes:   a pad nobody drives or pulls flips every cycle
`timescale 1ns/1ns
`default_nettype none
module pcc_pad_model (
  input  wire logic        sys_clk,    // system clock
  input  wire logic [15:0] pad_oe,     // device driver on
  input  wire logic [15:0] pad_out,    // device drive level
  input  wire logic [15:0] pad_pullup, // device pull-up on
  input  wire logic [15:0] ext_en,     // outside circuit drives
  input  wire logic [15:0] ext_val,    // outside drive level
  output var logic  [15:0] pad_lvl     // resolved pad level
);
  logic [15:0] last_q = 16'h0000;
  // a floating pad must not keep its old level, or stale reads pass
  always_ff @(posedge sys_clk) begin
    last_q <= pad_lvl;
  end
  // two drivers fighting give an unknown, never a polite winner
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pad_oe[i] && ext_en[i])
        pad_lvl[i] = (pad_out[i] == ext_val[i]) ? pad_out[i] : 1'bx;
      else if (pad_oe[i])
        pad_lvl[i] = pad_out[i];
      else if (ext_en[i])
        pad_lvl[i] = ext_val[i];
      else
        pad_lvl[i] = pad_pullup[i] ? 1'b1 : ~last_q[i];
    end
  end
endmodule : pcc_pad_model
`default_nettype wire

// ---- sim/pcc_top_tb_top.sv ----
// Purpose: self-checking bench for the port pin configuration block
// Assumes: pad model resolves pads; a watcher compares queued notes
// Notes:   config shows one clock later, pad reads five clocks later
`timescale 1ns/1ns
`default_nettype none
module pcc_top_tb_top;
  import pcc_pkg::*;
  typedef struct {int sel; logic [16:0] e; logic [16:0] m;} pcc_note_t;
  localparam logic [16:0] ALL = 17'h1FFFF;
  logic        sys_clk, resetn, rme, pgd, sel_c, dbg_act, dbg_out, dbg_oe;
  logic        irq0, irq1, osc_i, osc_o, dbg_in, pmatch;
  logic [15:0] kind, style, gpio, ext_en, ext_val, pad_in;
  logic [15:0] pad_out, pad_oe, pad_pu, prd;
  logic [14:0] skip;
  logic [3:0]  sel_a;
  logic [5:0]  sel_b;
  logic [16:0] psig_out, psig_drv, placed, got, psig_in;
  logic [7:0]  irq_sel, m0, v0;
  logic [6:0]  m1, v1;
  logic [2:0]  osc;
  logic [31:0] rnd = 32'h191C6D6E;
  int          err_count, n_tests, cyc, i;
  pcc_note_t   q[$];
  pcc_note_t   n;
  event        chk_ev;
  // routing table: bypass, selects, expected placed signals
  logic [14:0] rt_skip [4] = '{15'h7FFF, 15'h0000, 15'h7FF0, 15'h7F00};
  logic [3:0]  rt_a    [4] = '{4'h3, 4'h3, 4'hF, 4'h1};
  logic [5:0]  rt_b    [4] = '{6'h00, 6'h00, 6'h00, 6'h03};
  logic [16:0] rt_exp  [4] = '{17'h00003, 17'h0003F, 17'h0003F, 17'h00E03};
  logic [2:0]  os_code [5] = '{3'h6, 3'h7, 3'h4, 3'h5, 3'h1};
  logic [1:0]  os_exp  [5] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h0};

  pcc_top i_dut (
    .sys_clk(sys_clk), .resetn(resetn),
    .routing_matrix_enable(rme), .pullup_global_disable(pgd),
    .pin_input_kind_select(kind), .pin_drive_style_select(style),
    .route_bypass_bits(skip), .gpio_out_value(gpio),
    .peripheral_route_select_a(sel_a), .peripheral_route_select_b(sel_b),
    .peripheral_route_select_c(sel_c), .periph_sig_out(psig_out),
    .periph_sig_drive(psig_drv), .ext_irq_pin_select(irq_sel),
    .port0_compare_mask(m0), .port0_compare_value(v0),
    .port1_compare_mask(m1), .port1_compare_value(v1),
    .ext_osc_control(osc), .debug_link_active(dbg_act),
    .debug_link_data_out(dbg_out), .debug_link_data_oe(dbg_oe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pu), .port_read(prd), .periph_sig_in(psig_in),
    .periph_sig_placed(placed), .ext_irq0_level(irq0),
    .ext_irq1_level(irq1), .port_match(pmatch), .osc_pin_in_connect(osc_i),
    .osc_pin_out_connect(osc_o), .debug_link_data_in(dbg_in)
  );

  pcc_pad_model i_pads (
    .sys_clk(sys_clk), .pad_oe(pad_oe), .pad_out(pad_out),
    .pad_pullup(pad_pu), .ext_en(ext_en), .ext_val(ext_val),
    .pad_lvl(pad_in)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // outputs are registered, so look one edge plus a little later
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic note_exp(input int s, input logic [16:0] e, m);
    q.push_back('{s, e, m});
    -> chk_ev;
  endtask : note_exp

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // a hang ends as a mismatch; the whole run needs under 120 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  // watcher drains every note queued in this time step
  always @(chk_ev) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.sel)
        0: got = {1'b0, pad_oe};
        1: got = {1'b0, pad_out};
        2: got = {1'b0, pad_pu};
        3: got = {1'b0, prd};
        4: got = placed;
        5: got = {15'h0000, irq1, irq0};
        6: got = {15'h0000, osc_i, osc_o};
        8: got = {16'h0000, pmatch};
        9: got = psig_in;
        default: got = {16'h0000, dbg_in};
      endcase
      n_tests++;
      if ((got & n.m) !== (n.e & n.m)) begin
        err_count++;
        $display("unexpected at %0t sel %0d got %h exp %h", $time, n.sel,
                 got & n.m, n.e & n.m);
      end
    end
  end

  initial begin
    resetn = 1'b0; rme = 1'b0; pgd = 1'b0; sel_c = 1'b0;
    dbg_act = 1'b0; dbg_out = 1'b0; dbg_oe = 1'b0;
    kind = 16'hFFFF; style = 16'hFFFF; gpio = rnd[15:0];
    ext_en = 16'h0000; ext_val = 16'h0000; skip = 15'h7FFF;
    sel_a = 4'h0; sel_b = 6'h00; psig_out = 17'h00000; psig_drv = 17'h00000;
    irq_sel = 8'h00; osc = 3'h0;
    {m0, v0, m1, v1} = rnd[29:0];
    step(4);
    note_exp(0, 17'h00000, ALL);
    note_exp(2, 17'h0FFFF, ALL);
    resetn = 1'b1;
    step(2);
    note_exp(0, 17'h00000, ALL);
    note_exp(2, 17'h0FFFF, ALL);
    // push-pull with the matrix on, all pins kept as plain port pins
    rme = 1'b1; rnd = lfsr(rnd); gpio = rnd[15:0];
    step(1);
    note_exp(0, 17'h0FFFF, ALL);
    note_exp(1, {1'b0, gpio}, ALL);
    note_exp(2, 17'h00000, ALL);
    // open drain only ever pulls low
    style = 16'h0000; rnd = lfsr(rnd); gpio = rnd[15:0];
    step(1);
    note_exp(0, {1'b0, ~gpio}, ALL);
    note_exp(1, 17'h00000, {1'b0, ~gpio});
    note_exp(2, {1'b0, gpio}, ALL);
    pgd = 1'b1;
    step(1);
    note_exp(2, 17'h00000, ALL);
    // analog pins held high from outside still read as zero
    pgd = 1'b0; style = 16'hFFFF; gpio = 16'h0000;
    rnd = lfsr(rnd); kind = rnd[15:0]; ext_en = ~kind; ext_val = 16'hFFFF;
    step(1);
    note_exp(0, {1'b0, kind}, ALL);
    note_exp(2, 17'h00000, {1'b0, ~kind});
    step(5);
    note_exp(3, 17'h00000, ALL);
    note_exp(8, 17'(|({v1, v0} & {m1, m0} & kind[14:0])), ALL);
    // output value 1 floats, so the read shows the outside level
    kind = 16'hFFFF; style = 16'h0000; gpio = 16'hFFFF; sel_a = 4'hF;
    step(1);
    rnd = lfsr(rnd); ext_en = 16'hFFFF; ext_val = rnd[15:0];
    step(5);
    note_exp(3, {1'b0, ext_val}, ALL);
    note_exp(8, 17'(|((ext_val[14:0] ^ {v1, v0}) & {m1, m0})), ALL);
    note_exp(9, {15'h0000, ext_val[5:4]}, 17'h00003);
    // pin events: irq0 active low on pin i, irq1 on pin i+1 (pin 0 when i is 7)
    sel_a = 4'h0;
    for (i = 0; i < 8; i++) begin
      ext_val = ~(16'h0001 << i);
      irq_sel = {1'b0, 3'(i + 1), 1'b0, 3'(i)};
      step(5);
      note_exp(5, 17'h00001, 17'h00003);
      kind[i] = 1'b0;
      step(5);
      note_exp(5, 17'h00000, 17'h00003);
      kind[i] = 1'b1;
    end
    // routing: serial pins fixed, others fill free unbypassed pins
    ext_en = 16'h0000; style = 16'hFFFF; psig_drv = 17'h00001;
    for (i = 0; i < 4; i++) begin
      skip = rt_skip[i]; sel_a = rt_a[i]; sel_b = rt_b[i];
      rnd = lfsr(rnd); psig_out = rnd[16:0];
      step(1);
      note_exp(4, rt_exp[i], ALL);
      note_exp(0, 17'h00010, 17'h00010);
      note_exp(1, {12'h000, psig_out[0], 4'h0}, 17'h00010);
    end
    // oscillator modes with its pins analog and bypassed
    sel_a = 4'h0; sel_b = 6'h00; skip = 15'h7FFF; kind[3:2] = 2'h0;
    for (i = 0; i < 5; i++) begin
      osc = os_code[i];
      step(1);
      note_exp(6, {15'h0000, os_exp[i]}, ALL);
    end
    // debug link owns the last pad
    osc = 3'h0; kind = 16'hFFFF; dbg_act = 1'b1; dbg_oe = 1'b1;
    rnd = lfsr(rnd); dbg_out = rnd[0];
    step(1);
    note_exp(0, 17'h08000, 17'h08000);
    note_exp(1, {1'b0, dbg_out, 15'h0000}, 17'h08000);
    step(5);
    note_exp(7, {16'h0000, dbg_out}, ALL);
    step(1);
    wrap_up();
  end
endmodule : pcc_top_tb_top
`default_nettype wire
